/* ahc_ctrl_model.sv */
module ahc_ctrl_model (
	// Clock
	input wire logic core_clk,
	// Command to the block
	output logic cmdValid,
	output logic cmdQuery,
	output ahc_pkg::ahc_setting_t cmdSetting,
	output ahc_pkg::ahc_keyword_t cmdKeyword,
	output ahc_pkg::ahc_val_t cmdValue
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmdValid = 1'h0;
		cmdQuery = 1'h0;
		cmdSetting = ahc_pkg::SET_LINE_CYCLES;
		cmdKeyword = ahc_pkg::KW_VALUE;
		cmdValue = '0;
	end
	// One command, taken at the next edge, then withdrawn
	task automatic send(input logic q, input ahc_pkg::ahc_setting_t s,
		input ahc_pkg::ahc_keyword_t k, input ahc_pkg::ahc_val_t v);
		@(posedge core_clk);
		#2;
		cmdValid = 1'h1;
		cmdQuery = q;
		cmdSetting = s;
		cmdKeyword = k;
		cmdValue = v;
		@(posedge core_clk);
		#2;
		cmdValid = 1'h0;
		cmdQuery = ~q;
		cmdValue = ~v;
	endtask
endmodule

/* ahc_pkg.sv */
package ahc_pkg;
	// ==========================================================
	// Value format
	// Signed fixed point, one LSB = 1E-18 of the base unit
	localparam int VAL_W = 128;
	typedef logic signed [VAL_W-1:0] ahc_val_t;
	localparam ahc_val_t ONE = 128'h0000_0000_0000_0000_0DE0_B6B3_A764_0000;
	localparam ahc_val_t MILLI = ONE / ahc_val_t'(1000);

	// ==========================================================
	// Commands
	typedef enum logic [2:0] {
		SET_LINE_CYCLES,
		SET_SAMPLE_RATE,
		SET_INTEG_TIME,
		SET_AUTO_RANGE,
		SET_RANGE,
		SET_OFFSET_ENABLE,
		SET_OFFSET_VALUE,
		SET_BANDWIDTH
	} ahc_setting_t;

	typedef enum logic [1:0] {
		KW_VALUE,
		KW_MIN,
		KW_MAX,
		KW_DEFAULT
	} ahc_keyword_t;

	// ==========================================================
	// Setting tables
	localparam ahc_val_t NPLC_A = ONE;
	localparam ahc_val_t NPLC_B_50 = ahc_val_t'(5) * ONE;
	localparam ahc_val_t NPLC_B_60 = ahc_val_t'(6) * ONE;
	localparam ahc_val_t NPLC_C_50 = ahc_val_t'(20) * ONE;
	localparam ahc_val_t NPLC_C_60 = ahc_val_t'(24) * ONE;
	localparam ahc_val_t SAMPLE_RATE_SETTING_A = (ahc_val_t'(5) * ONE) / ahc_val_t'(2);
	localparam ahc_val_t SAMPLE_RATE_SETTING_B = ahc_val_t'(10) * ONE;
	localparam ahc_val_t SAMPLE_RATE_SETTING_C_50 = ahc_val_t'(50) * ONE;
	localparam ahc_val_t SAMPLE_RATE_SETTING_C_60 = ahc_val_t'(60) * ONE;
	localparam ahc_val_t APER_A_50 = ahc_val_t'(20) * MILLI;
	localparam ahc_val_t APER_A_60 = (ahc_val_t'(16667) * MILLI) / ahc_val_t'(1000);
	localparam ahc_val_t APER_B = ahc_val_t'(100) * MILLI;
	localparam ahc_val_t APER_C = ahc_val_t'(400) * MILLI;
	localparam ahc_val_t RANGE_A = ONE;
	localparam ahc_val_t RANGE_B = ahc_val_t'(3) * ONE;
	localparam ahc_val_t BW_A = ahc_val_t'(20) * ONE;
	localparam ahc_val_t BW_B = ahc_val_t'(200) * ONE;
	localparam ahc_val_t OFS_MAX = ahc_val_t'(9999999) * ONE * ahc_val_t'(100000000);
	localparam ahc_val_t OFS_MIN = -OFS_MAX;
	localparam ahc_val_t OFS_DEF = 128'h0000_0000_0000_0000_0000_0000_0000_0000;

	// ==========================================================
	// Reset and default values
	localparam logic [1:0] NPLC_DEF_IDX = 2'h2;
	localparam logic [1:0] SAMPLE_RATE_SETTING_DEF_IDX = 2'h0;
	localparam logic [1:0] APER_DEF_IDX = 2'h2;
	localparam logic [1:0] RANGE_DEF_IDX = 2'h0;
	localparam logic [1:0] BW_DEF_IDX = 2'h0;
	localparam logic [1:0] BW_MID_IDX = 2'h0;
	localparam logic AUTO_RANGE_DEF = 1'b0;
	localparam logic OFS_ENABLE_DEF = 1'b0;
endpackage

/* ahc_settings.sv */
module ahc_settings (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Command from the parser
	input wire logic cmdValid,
	input wire logic cmdQuery,
	input wire ahc_pkg::ahc_setting_t cmdSetting,
	input wire ahc_pkg::ahc_keyword_t cmdKeyword,
	input wire ahc_pkg::ahc_val_t cmdValue,
	// Instrument status
	input wire logic mains60Pin,
	input wire logic trigWait,
	input wire logic measuring,
	// Response
	output logic respValid,
	output ahc_pkg::ahc_val_t respData,
	output logic respExponent,
	output logic execError,
	// Current settings
	output ahc_pkg::ahc_val_t lineCycleCount,
	output ahc_pkg::ahc_val_t sampleRate,
	output ahc_pkg::ahc_val_t integrationTime,
	output logic autoRange,
	output ahc_pkg::ahc_val_t rangeValue,
	output logic offsetEnable,
	output ahc_pkg::ahc_val_t offsetValue,
	output ahc_pkg::ahc_val_t bandwidth
);
	// ==========================================================
	// Table lookup
	// Count of listed entries; zero for the switches and the offset value
	function automatic logic [1:0] tblCount(input ahc_pkg::ahc_setting_t s);
		case (s)
			ahc_pkg::SET_LINE_CYCLES, ahc_pkg::SET_SAMPLE_RATE,
			ahc_pkg::SET_INTEG_TIME: tblCount = 2'h3;
			ahc_pkg::SET_RANGE, ahc_pkg::SET_BANDWIDTH: tblCount = 2'h2;
			default: tblCount = 2'h0;
		endcase
	endfunction

	// Listed entry i of a setting, ascending, at the given mains frequency
	function automatic ahc_pkg::ahc_val_t tblEntry(input ahc_pkg::ahc_setting_t s,
			input logic [1:0] i, input logic m60);
		tblEntry = ahc_pkg::OFS_DEF;
		case (s)
			ahc_pkg::SET_LINE_CYCLES: begin
				if (i == 2'h0) tblEntry = ahc_pkg::NPLC_A;
				else if (i == 2'h1) tblEntry = m60 ? ahc_pkg::NPLC_B_60 : ahc_pkg::NPLC_B_50;
				else tblEntry = m60 ? ahc_pkg::NPLC_C_60 : ahc_pkg::NPLC_C_50;
			end
			ahc_pkg::SET_SAMPLE_RATE: begin
				if (i == 2'h0) tblEntry = ahc_pkg::SAMPLE_RATE_SETTING_A;
				else if (i == 2'h1) tblEntry = ahc_pkg::SAMPLE_RATE_SETTING_B;
				else tblEntry = m60 ? ahc_pkg::SAMPLE_RATE_SETTING_C_60 : ahc_pkg::SAMPLE_RATE_SETTING_C_50;
			end
			ahc_pkg::SET_INTEG_TIME: begin
				if (i == 2'h0) tblEntry = m60 ? ahc_pkg::APER_A_60 : ahc_pkg::APER_A_50;
				else if (i == 2'h1) tblEntry = ahc_pkg::APER_B;
				else tblEntry = ahc_pkg::APER_C;
			end
			ahc_pkg::SET_RANGE: begin
				tblEntry = (i == 2'h0) ? ahc_pkg::RANGE_A : ahc_pkg::RANGE_B;
			end
			ahc_pkg::SET_BANDWIDTH: begin
				tblEntry = (i == 2'h0) ? ahc_pkg::BW_A : ahc_pkg::BW_B;
			end
			default: tblEntry = ahc_pkg::OFS_DEF;
		endcase
	endfunction

	// Table index of the default entry
	function automatic logic [1:0] defIdx(input ahc_pkg::ahc_setting_t s);
		case (s)
			ahc_pkg::SET_LINE_CYCLES: defIdx = ahc_pkg::NPLC_DEF_IDX;
			ahc_pkg::SET_SAMPLE_RATE: defIdx = ahc_pkg::SAMPLE_RATE_SETTING_DEF_IDX;
			ahc_pkg::SET_INTEG_TIME: defIdx = ahc_pkg::APER_DEF_IDX;
			ahc_pkg::SET_RANGE: defIdx = ahc_pkg::RANGE_DEF_IDX;
			default: defIdx = ahc_pkg::BW_DEF_IDX;
		endcase
	endfunction

	// ==========================================================
	// Mains frequency synchroniser
	// Two flops, as the mains pin is not timed to core_clk
	logic mainsMeta;
	logic mains60;
	logic next_mainsMeta;
	logic next_mains60;

	always_comb begin
		next_mainsMeta = mains60Pin;
		next_mains60 = mainsMeta;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mainsMeta <= 1'b0;
			mains60 <= 1'b0;
		end else begin
			mainsMeta <= next_mainsMeta;
			mains60 <= next_mains60;
		end
	end

	// ==========================================================
	// Setting state
	logic [1:0] nplcIdx, srateIdx, aperIdx, rangeIdx, bwIdx;
	logic [1:0] next_nplcIdx, next_srateIdx, next_aperIdx, next_rangeIdx, next_bwIdx;
	logic next_autoRange, next_offsetEnable, next_respValid, next_respExponent, next_execError;
	ahc_pkg::ahc_val_t next_offsetValue, next_respData;
	ahc_pkg::ahc_val_t next_lineCycleCount, next_sampleRate, next_integrationTime;
	ahc_pkg::ahc_val_t next_rangeValue, next_bandwidth;

	// One command per cycle: queries answered, sets applied or refused
	always_comb begin
		logic [1:0] cnt;
		logic [1:0] idx;
		logic err;
		ahc_pkg::ahc_val_t lo;
		ahc_pkg::ahc_val_t hi;
		cnt = tblCount(cmdSetting);
		idx = 2'h0;
		err = 1'b0;
		// Table span of the addressed setting
		lo = tblEntry(cmdSetting, 2'h0, mains60);
		hi = tblEntry(cmdSetting, cnt - 2'h1, mains60);
		next_nplcIdx = nplcIdx;
		next_srateIdx = srateIdx;
		next_aperIdx = aperIdx;
		next_rangeIdx = rangeIdx;
		next_bwIdx = bwIdx;
		next_autoRange = autoRange;
		next_offsetEnable = offsetEnable;
		next_offsetValue = offsetValue;
		next_respValid = 1'b0;
		next_respData = respData;
		next_respExponent = respExponent;
		next_execError = 1'b0;
		// Table index chosen by keyword or by value
		case (cmdKeyword)
			ahc_pkg::KW_MIN: idx = 2'h0;
			ahc_pkg::KW_MAX: idx = cnt - 2'h1;
			ahc_pkg::KW_DEFAULT: idx = defIdx(cmdSetting);
			default: begin
				// Outside the span: take the nearer end and flag it
				if (cmdValue < lo) begin
					idx = 2'h0;
					err = 1'b1;
				end else if (cmdValue > hi) begin
					idx = cnt - 2'h1;
					err = 1'b1;
				end else if (cmdSetting == ahc_pkg::SET_SAMPLE_RATE) begin
					// Sample rate rounds down to a listed entry
					for (int i = 0; i < 3; i++) begin
						if (2'(i) < cnt && tblEntry(cmdSetting, 2'(i), mains60) <= cmdValue)
							idx = 2'(i);
					end
				end else begin
					// Other tables round up to a listed entry
					for (int i = 2; i >= 0; i--) begin
						if (2'(i) < cnt && tblEntry(cmdSetting, 2'(i), mains60) >= cmdValue)
							idx = 2'(i);
					end
				end
			end
		endcase
		// Queries are never refused; switches answer in integer form
		if (cmdValid && cmdQuery) begin
			next_respValid = 1'b1;
			next_respExponent = 1'b1;
			case (cmdSetting)
				ahc_pkg::SET_AUTO_RANGE: begin
					next_respData = ahc_pkg::ahc_val_t'(autoRange);
					next_respExponent = 1'b0;
				end
				ahc_pkg::SET_OFFSET_ENABLE: begin
					next_respData = ahc_pkg::ahc_val_t'(offsetEnable);
					next_respExponent = 1'b0;
				end
				ahc_pkg::SET_OFFSET_VALUE: begin
					if (cmdKeyword == ahc_pkg::KW_MIN) next_respData = ahc_pkg::OFS_MIN;
					else if (cmdKeyword == ahc_pkg::KW_MAX) next_respData = ahc_pkg::OFS_MAX;
					else next_respData = offsetValue;
				end
				default: begin
					// Tables: the limit for MIN or MAX, else the stored value
					if (cmdKeyword == ahc_pkg::KW_MIN) next_respData = lo;
					else if (cmdKeyword == ahc_pkg::KW_MAX) next_respData = hi;
					else if (cmdSetting == ahc_pkg::SET_LINE_CYCLES) next_respData = lineCycleCount;
					else if (cmdSetting == ahc_pkg::SET_SAMPLE_RATE) next_respData = sampleRate;
					else if (cmdSetting == ahc_pkg::SET_INTEG_TIME) next_respData = integrationTime;
					else if (cmdSetting == ahc_pkg::SET_RANGE) next_respData = rangeValue;
					else next_respData = bandwidth;
				end
			endcase
		end else if (cmdValid && (trigWait || measuring)) begin
			// Busy: the set is dropped, only the error is flagged
			next_execError = 1'b1;
		end else if (cmdValid) begin
			case (cmdSetting)
				ahc_pkg::SET_LINE_CYCLES: next_nplcIdx = idx;
				ahc_pkg::SET_SAMPLE_RATE: next_srateIdx = idx;
				ahc_pkg::SET_INTEG_TIME: next_aperIdx = idx;
				ahc_pkg::SET_RANGE: begin
					// An explicit range turns auto range off
					next_rangeIdx = idx;
					next_autoRange = 1'b0;
				end
				ahc_pkg::SET_BANDWIDTH: next_bwIdx = idx;
				ahc_pkg::SET_AUTO_RANGE: next_autoRange = (cmdValue != '0);
				ahc_pkg::SET_OFFSET_ENABLE: next_offsetEnable = (cmdValue != '0);
				default: begin
					// Offset value is free-form, clamped to its own span
					err = 1'b0;
					if (cmdKeyword == ahc_pkg::KW_MIN) next_offsetValue = ahc_pkg::OFS_MIN;
					else if (cmdKeyword == ahc_pkg::KW_MAX) next_offsetValue = ahc_pkg::OFS_MAX;
					else if (cmdKeyword == ahc_pkg::KW_DEFAULT) next_offsetValue = ahc_pkg::OFS_DEF;
					else if (cmdValue > ahc_pkg::OFS_MAX) begin
						next_offsetValue = ahc_pkg::OFS_MAX;
						err = 1'b1;
					end else if (cmdValue < ahc_pkg::OFS_MIN) begin
						next_offsetValue = ahc_pkg::OFS_MIN;
						err = 1'b1;
					end else next_offsetValue = cmdValue;
				end
			endcase
			// Switch sets take any number and never flag
			if (cmdSetting == ahc_pkg::SET_AUTO_RANGE || cmdSetting == ahc_pkg::SET_OFFSET_ENABLE)
				err = 1'b0;
			next_execError = err;
		end
		// Mid band pins line cycles, rate and time to their defaults
		if (next_bwIdx == ahc_pkg::BW_MID_IDX) begin
			next_nplcIdx = ahc_pkg::NPLC_DEF_IDX;
			next_srateIdx = ahc_pkg::SAMPLE_RATE_SETTING_DEF_IDX;
			next_aperIdx = ahc_pkg::APER_DEF_IDX;
		end
		// Values follow the synchronised mains, so a mains change re-maps them
		next_lineCycleCount = tblEntry(ahc_pkg::SET_LINE_CYCLES, next_nplcIdx, mains60);
		next_sampleRate = tblEntry(ahc_pkg::SET_SAMPLE_RATE, next_srateIdx, mains60);
		next_integrationTime = tblEntry(ahc_pkg::SET_INTEG_TIME, next_aperIdx, mains60);
		next_rangeValue = tblEntry(ahc_pkg::SET_RANGE, next_rangeIdx, mains60);
		next_bandwidth = tblEntry(ahc_pkg::SET_BANDWIDTH, next_bwIdx, mains60);
	end

	// Reset values are the 50 Hz entries, as the synchronised mains resets low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nplcIdx <= ahc_pkg::NPLC_DEF_IDX;
			srateIdx <= ahc_pkg::SAMPLE_RATE_SETTING_DEF_IDX;
			aperIdx <= ahc_pkg::APER_DEF_IDX;
			rangeIdx <= ahc_pkg::RANGE_DEF_IDX;
			bwIdx <= ahc_pkg::BW_DEF_IDX;
			autoRange <= ahc_pkg::AUTO_RANGE_DEF;
			offsetEnable <= ahc_pkg::OFS_ENABLE_DEF;
			offsetValue <= ahc_pkg::OFS_DEF;
			respValid <= 1'b0;
			respData <= ahc_pkg::OFS_DEF;
			respExponent <= 1'b0;
			execError <= 1'b0;
			lineCycleCount <= ahc_pkg::NPLC_C_50;
			sampleRate <= ahc_pkg::SAMPLE_RATE_SETTING_A;
			integrationTime <= ahc_pkg::APER_C;
			rangeValue <= ahc_pkg::RANGE_A;
			bandwidth <= ahc_pkg::BW_A;
		end else begin
			nplcIdx <= next_nplcIdx;
			srateIdx <= next_srateIdx;
			aperIdx <= next_aperIdx;
			rangeIdx <= next_rangeIdx;
			bwIdx <= next_bwIdx;
			autoRange <= next_autoRange;
			offsetEnable <= next_offsetEnable;
			offsetValue <= next_offsetValue;
			respValid <= next_respValid;
			respData <= next_respData;
			respExponent <= next_respExponent;
			execError <= next_execError;
			lineCycleCount <= next_lineCycleCount;
			sampleRate <= next_sampleRate;
			integrationTime <= next_integrationTime;
			rangeValue <= next_rangeValue;
			bandwidth <= next_bandwidth;
		end
	end
endmodule

/* ahc_settings_monitor.sv */
module ahc_settings_monitor (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Command and status
	input wire logic cmdValid,
	input wire logic cmdQuery,
	input wire ahc_pkg::ahc_setting_t cmdSetting,
	input wire ahc_pkg::ahc_keyword_t cmdKeyword,
	input wire logic trigWait,
	input wire logic measuring,
	// Results
	input wire logic respValid,
	input wire ahc_pkg::ahc_val_t respData,
	input wire logic respExponent,
	input wire logic execError,
	input wire logic autoRange,
	input wire ahc_pkg::ahc_val_t sampleRate,
	input wire ahc_pkg::ahc_val_t integrationTime,
	input wire ahc_pkg::ahc_val_t rangeValue,
	input wire ahc_pkg::ahc_val_t bandwidth
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic setCmd;
	logic busy;
	logic qry;
	assign setCmd = cmdValid && !cmdQuery;
	assign busy = trigWait || measuring;
	assign qry = cmdValid && cmdQuery;
	// ==========================================================
	// Checks
	refuse_err_a: assert property (setCmd && busy |=> execError)
		else $error("refused set gave no error");
	refuse_hold_a: assert property (setCmd && busy |=> $stable(rangeValue)
		&& $stable(bandwidth) && $stable(autoRange)) else $error("refused set changed state");
	err_idle_a: assert property (!setCmd |=> !execError)
		else $error("error without set");
	resp_now_a: assert property (qry |=> respValid ##1 (respValid == $past(qry)))
		else $error("answer timing wrong");
	range_auto_a: assert property (setCmd && !busy && cmdSetting == ahc_pkg::SET_RANGE
		|=> !autoRange) else $error("range set left auto on");
	range_legal_a: assert property (rangeValue == ahc_pkg::RANGE_A
		|| rangeValue == ahc_pkg::RANGE_B) else $error("range off table");
	mid_hold_a: assert property (bandwidth == ahc_pkg::BW_A |->
		sampleRate == ahc_pkg::SAMPLE_RATE_SETTING_A && integrationTime == ahc_pkg::APER_C)
		else $error("mid band not at defaults");
	switch_int_a: assert property (qry && cmdSetting == ahc_pkg::SET_AUTO_RANGE
		|=> !respExponent) else $error("switch answer not integer");
	num_exp_a: assert property (qry && cmdSetting == ahc_pkg::SET_RANGE
		|=> respExponent) else $error("range answer not exponent");
	range_ans_a: assert property (qry && cmdSetting == ahc_pkg::SET_RANGE
		&& cmdKeyword == ahc_pkg::KW_VALUE |=> respData == $past(rangeValue))
		else $error("range answer not current range");
endmodule

bind ahc_settings ahc_settings_monitor u_mon (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.cmdValid(cmdValid),
	.cmdQuery(cmdQuery),
	.cmdSetting(cmdSetting),
	.cmdKeyword(cmdKeyword),
	.trigWait(trigWait),
	.measuring(measuring),
	.respValid(respValid),
	.respData(respData),
	.respExponent(respExponent),
	.execError(execError),
	.autoRange(autoRange),
	.sampleRate(sampleRate),
	.integrationTime(integrationTime),
	.rangeValue(rangeValue),
	.bandwidth(bandwidth)
);

/* testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam ahc_pkg::ahc_val_t U = ahc_pkg::ONE;
	logic core_clk, rst_n, mains60Pin, trigWait, measuring;
	logic cmdValid, cmdQuery, respValid, respExponent, execError, autoRange, offsetEnable;
	ahc_pkg::ahc_setting_t cmdSetting;
	ahc_pkg::ahc_keyword_t cmdKeyword;
	ahc_pkg::ahc_val_t cmdValue, respData, lineCycleCount, sampleRate, integrationTime;
	ahc_pkg::ahc_val_t rangeValue, offsetValue, bandwidth;
	int err_total = 0;
	int checked = 0;
	ahc_settings u_dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.cmdValid(cmdValid),
		.cmdQuery(cmdQuery),
		.cmdSetting(cmdSetting),
		.cmdKeyword(cmdKeyword),
		.cmdValue(cmdValue),
		.mains60Pin(mains60Pin),
		.trigWait(trigWait),
		.measuring(measuring),
		.respValid(respValid),
		.respData(respData),
		.respExponent(respExponent),
		.execError(execError),
		.lineCycleCount(lineCycleCount),
		.sampleRate(sampleRate),
		.integrationTime(integrationTime),
		.autoRange(autoRange),
		.rangeValue(rangeValue),
		.offsetEnable(offsetEnable),
		.offsetValue(offsetValue),
		.bandwidth(bandwidth)
	);
	ahc_ctrl_model u_ctl (
		.core_clk(core_clk),
		.cmdValid(cmdValid),
		.cmdQuery(cmdQuery),
		.cmdSetting(cmdSetting),
		.cmdKeyword(cmdKeyword),
		.cmdValue(cmdValue)
	);
	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic chk(input string n, input ahc_pkg::ahc_val_t got, input ahc_pkg::ahc_val_t e);
		checked++;
		if (got !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, got);
		end
	endtask
	task automatic cmd(input logic q, input ahc_pkg::ahc_setting_t s,
		input ahc_pkg::ahc_keyword_t k, input ahc_pkg::ahc_val_t v, input logic e);
		u_ctl.send(q, s, k, v);
		chk("execError", execError, e);
		chk("respValid", respValid, q);
	endtask
	task automatic st(input ahc_pkg::ahc_setting_t s, input ahc_pkg::ahc_val_t v, input logic e);
		cmd(1'h0, s, ahc_pkg::KW_VALUE, v, e);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("cycles", lineCycleCount, ahc_pkg::NPLC_C_50);
		chk("rate", sampleRate, ahc_pkg::SAMPLE_RATE_SETTING_A);
		chk("time", integrationTime, ahc_pkg::APER_C);
		chk("bw", bandwidth, ahc_pkg::BW_A);
		chk("offset", offsetValue, ahc_pkg::OFS_DEF);
		chk("range", rangeValue, ahc_pkg::RANGE_A);
		chk("auto", autoRange, ahc_pkg::AUTO_RANGE_DEF);
		chk("ofsOn", offsetEnable, ahc_pkg::OFS_ENABLE_DEF);
		st(ahc_pkg::SET_SAMPLE_RATE, 10 * U, 1'h0);
		chk("rate", sampleRate, ahc_pkg::SAMPLE_RATE_SETTING_A);
		$display("reset test done");
	endtask
	task automatic t_round();
		st(ahc_pkg::SET_BANDWIDTH, 150 * U, 1'h0);
		chk("bw", bandwidth, ahc_pkg::BW_B);
		st(ahc_pkg::SET_SAMPLE_RATE, 30 * U, 1'h0);
		chk("rate", sampleRate, ahc_pkg::SAMPLE_RATE_SETTING_B);
		st(ahc_pkg::SET_SAMPLE_RATE, 99 * U, 1'h1);
		chk("rate", sampleRate, ahc_pkg::SAMPLE_RATE_SETTING_C_50);
		st(ahc_pkg::SET_LINE_CYCLES, 3 * U, 1'h0);
		chk("cycles", lineCycleCount, ahc_pkg::NPLC_B_50);
		st(ahc_pkg::SET_INTEG_TIME, 50 * ahc_pkg::MILLI, 1'h0);
		chk("time", integrationTime, ahc_pkg::APER_B);
		$display("rounding test done");
	endtask
	task automatic t_range();
		st(ahc_pkg::SET_AUTO_RANGE, 7, 1'h0);
		chk("auto", autoRange, 1'h1);
		cmd(1'h1, ahc_pkg::SET_AUTO_RANGE, ahc_pkg::KW_VALUE, 0, 1'h0);
		chk("autoFmt", respExponent, 1'h0);
		chk("autoAns", respData, 1);
		st(ahc_pkg::SET_RANGE, 5 * U, 1'h1);
		chk("range", rangeValue, ahc_pkg::RANGE_B);
		chk("auto", autoRange, 1'h0);
		cmd(1'h1, ahc_pkg::SET_RANGE, ahc_pkg::KW_VALUE, 0, 1'h0);
		chk("answer", respData, ahc_pkg::RANGE_B);
		chk("fmt", respExponent, 1'h1);
		cmd(1'h1, ahc_pkg::SET_RANGE, ahc_pkg::KW_MIN, 0, 1'h0);
		chk("answer", respData, ahc_pkg::RANGE_A);
		$display("range test done");
	endtask
	task automatic t_refuse();
		trigWait = 1'h1;
		st(ahc_pkg::SET_BANDWIDTH, 20 * U, 1'h1);
		chk("bw", bandwidth, ahc_pkg::BW_B);
		trigWait = 1'h0;
		measuring = 1'h1;
		st(ahc_pkg::SET_RANGE, U, 1'h1);
		chk("range", rangeValue, ahc_pkg::RANGE_B);
		measuring = 1'h0;
		$display("refusal test done");
	endtask
	task automatic t_offset();
		st(ahc_pkg::SET_OFFSET_ENABLE, 5, 1'h0);
		chk("ofsOn", offsetEnable, 1'h1);
		st(ahc_pkg::SET_OFFSET_VALUE, ahc_pkg::OFS_MAX + 1, 1'h1);
		chk("offset", offsetValue, ahc_pkg::OFS_MAX);
		cmd(1'h0, ahc_pkg::SET_OFFSET_VALUE, ahc_pkg::KW_MIN, 0, 1'h0);
		chk("offset", offsetValue, ahc_pkg::OFS_MIN);
		cmd(1'h0, ahc_pkg::SET_OFFSET_VALUE, ahc_pkg::KW_DEFAULT, 0, 1'h0);
		chk("offset", offsetValue, ahc_pkg::OFS_DEF);
		$display("offset test done");
	endtask
	task automatic t_mains();
		mains60Pin = 1'h1;
		repeat (3) @(posedge core_clk);
		#2;
		chk("cycles", lineCycleCount, ahc_pkg::NPLC_B_60);
		cmd(1'h0, ahc_pkg::SET_SAMPLE_RATE, ahc_pkg::KW_MAX, 0, 1'h0);
		chk("rate", sampleRate, ahc_pkg::SAMPLE_RATE_SETTING_C_60);
		$display("mains test done");
	endtask
	initial begin
		repeat (5000) @(posedge core_clk);
		err_total++;
		conclude();
	end
	initial begin
		rst_n = 1'h0;
		mains60Pin = 1'h0;
		trigWait = 1'h0;
		measuring = 1'h0;
		repeat (20) @(posedge core_clk);
		#2;
		rst_n = 1'h1;
		t_reset();
		t_round();
		t_range();
		t_refuse();
		t_offset();
		t_mains();
		conclude();
	end
endmodule
